// ### cfs_exec.v
// Purpose: executes calls, returns, trap, sleep, condition register ops and block copy
// Assumes: instruction and operands are placed by software, memory is the local byte array
// Notes: every execution state is one ref_clk cycle; busy spans the whole state count, one state less for block copy
//
// Functional notes
// - indirect call pushes pc, loads vector
// - relative branch pushes pc, adds displacement
// - register call pushes pc, loads register
// - trap pushes pc and ccr, sets mask
// - exception return pops ccr then pc
// - sleep enters power-down, flags untouched
// - load ccr postincrement adds two
// - store ccr predecrement subtracts two first
// - store ccr is word, flags unchanged
// - and/or/xor immediate onto ccr
// - block copy loops until count zero
// - word half-carry from bit eleven
// - longword half-carry from bit twenty-seven
// - extended add keeps zero only if zero
// - decimal adjust carry set or kept
// - signed divide negative from divisor sign
// - divide zero flag from divisor zero
// - quotient-sign variant sets negative flag
// - state count is weighted cycle sum
// - memory two states, peripherals two/three
// - shared cell picks by nibble msb
`timescale 1ns/1ps
`include "cfs_defs.vh"

module cfs_exec #(
  parameter AW = 8,
  parameter [7:0] PERIPH_BASE = 8'hC0,
  parameter [7:0] PERIPH_STATES = 8'h03,
  parameter [31:0] TRAP_VEC_BASE = 32'h0000_0010
) (
  // clock and reset
  input wire ref_clk,
  input wire reset,
  // axi4-lite write address and data
  input wire s_axi_awvalid,
  output reg s_axi_awready,
  input wire [7:0] s_axi_awaddr,
  input wire s_axi_wvalid,
  output reg s_axi_wready,
  input wire [31:0] s_axi_wdata,
  input wire [3:0] s_axi_wstrb,
  // axi4-lite write response
  output reg s_axi_bvalid,
  input wire s_axi_bready,
  output reg [1:0] s_axi_bresp,
  // axi4-lite read
  input wire s_axi_arvalid,
  output reg s_axi_arready,
  input wire [7:0] s_axi_araddr,
  output reg s_axi_rvalid,
  input wire s_axi_rready,
  output reg [31:0] s_axi_rdata,
  output reg [1:0] s_axi_rresp,
  // core status
  output reg busy,
  output reg sleep
);

  // ----------------------------------------
  // helpers
  // ----------------------------------------
  // byte-lane merge for register writes
  function [31:0] merge;
    input [31:0] old;
    input [31:0] nw;
    input [3:0] strb;
    integer b;
    begin
      merge = old;
      for (b = 0; b < 4; b = b + 1) begin
        if (strb[b]) merge[b*8 +: 8] = nw[b*8 +: 8];
      end
    end
  endfunction

  // states per access cycle at an address
  function [7:0] sacc;
    input [31:0] a;
    begin
      sacc = (a[AW-1:0] >= PERIPH_BASE[AW-1:0]) ? PERIPH_STATES : `CFS_S_MEM;
    end
  endfunction

  // weighted cycle sum; fetches always come from on-chip memory
  function [7:0] cost;
    input [7:0] i, j, k, m, n, sj, sk, sm;
    begin
      cost = i * `CFS_S_MEM + j * sj + k * sk + m * sm + n * `CFS_S_INTERNAL;
    end
  endfunction

  // a shared opcode cell picks its second instruction when this is 1
  function second_of_cell;
    input [7:0] b;
    begin
      second_of_cell = b[7];
    end
  endfunction

  // ----------------------------------------
  // state
  // ----------------------------------------
  localparam [1:0] ST_IDLE = 2'd0;
  localparam [1:0] ST_EXEC = 2'd1;
  localparam [1:0] ST_COPY = 2'd2;
  localparam [1:0] ST_WAIT = 2'd3;

  reg [7:0] mem [0:(1<<AW)-1]; // local memory, upper part behaves as peripheral space
  reg [31:0] er [0:7]; // general long registers, er[7] is the stack pointer
  reg [1:0] state_reg;
  reg [31:0] pc_reg;
  reg [7:0] ccr_reg;
  reg [31:0] insn_reg; // instruction bytes, first byte in bits 31:24
  reg [31:0] ext_reg; // extension word, 16-bit displacement in bits 31:16
  reg adv_reg; // advanced (24-bit) address mode
  reg err_reg; // last opcode was not recognised
  reg [7:0] states_reg; // state count of the last instruction
  reg [7:0] wait_reg;
  reg [1:0] sub_reg; // states within one copy pass
  reg word_copy_reg; // copy count lives in the 16-bit register
  reg [2:0] reg_sel_reg;
  reg [AW-1:0] mem_addr_reg;
  reg [31:0] flag_a_reg, flag_b_reg;
  // axi holding registers
  reg aw_full, w_full;
  reg [7:0] aw_addr;
  reg [31:0] w_data;
  reg [3:0] w_strb;

  // ----------------------------------------
  // decode and effects of one instruction
  // ----------------------------------------
  reg [31:0] pc_next, er_dat, wr_addr, sp, pc_ret, vaddr, daddr;
  reg [47:0] wr_data;
  reg [2:0] wr_len, er_idx;
  reg er_we, err_next, sleep_set, copy_go;
  reg [7:0] ccr_next, cost_next, kw;

  always @* begin
    sp = er[7];
    kw = adv_reg ? 8'h02 : 8'h01; // stack words per program counter
    pc_ret = pc_reg + 32'h2;
    pc_next = pc_ret;
    ccr_next = ccr_reg;
    er_we = 1'b0;
    er_idx = 3'd7;
    er_dat = sp;
    wr_len = 3'd0;
    wr_addr = sp;
    wr_data = 48'h0000_0000_0000;
    err_next = 1'b0;
    sleep_set = 1'b0;
    copy_go = 1'b0;
    vaddr = 32'h0000_0000;
    daddr = er[insn_reg[6:4]];
    cost_next = cost(8'h01, 8'h00, 8'h00, 8'h00, 8'h00, 8'h01, 8'h01, 8'h01);
    case (insn_reg[31:24])
      8'h00, 8'h01: begin
        if (insn_reg[31:16] == 16'h0000) begin
          pc_next = pc_ret; // no_operation
        end else if (insn_reg[31:16] == 16'h0180) begin
          sleep_set = 1'b1; // ccr left as is
        end else if (insn_reg[31:16] == 16'h0140 && (insn_reg[15:8] == 8'h6D || insn_reg[15:8] == 8'h6F)) begin
          er_idx = insn_reg[6:4];
          pc_next = pc_reg + ((insn_reg[15:8] == 8'h6F) ? 32'h6 : 32'h4);
          if (insn_reg[15:8] == 8'h6F) begin
            daddr = er[insn_reg[6:4]] + {{16{ext_reg[31]}}, ext_reg[31:16]};
          end else if (second_of_cell(insn_reg[7:0])) begin
            daddr = er[insn_reg[6:4]] - 32'h2; // predecrement before the write
            er_we = 1'b1;
            er_dat = daddr;
          end else begin
            er_we = 1'b1; // postincrement after the read
            er_dat = daddr + 32'h2;
          end
          if (second_of_cell(insn_reg[7:0])) begin
            wr_len = 3'd2; // word store, flags unchanged
            wr_addr = daddr;
            wr_data = {ccr_reg, ccr_reg, 32'h0000_0000};
          end else begin
            ccr_next = mem[daddr[AW-1:0]];
          end
          cost_next = cost((insn_reg[15:8] == 8'h6F) ? 8'h03 : 8'h02, 8'h00, 8'h00, 8'h01,
                           (insn_reg[15:8] == 8'h6F) ? 8'h00 : 8'h02, 8'h01, 8'h01, sacc(daddr));
        end else begin
          err_next = 1'b1;
        end
      end
      8'h04: ccr_next = ccr_reg | insn_reg[23:16];
      8'h05: ccr_next = ccr_reg ^ insn_reg[23:16];
      8'h06: ccr_next = ccr_reg & insn_reg[23:16];
      8'h07: ccr_next = insn_reg[23:16];
      8'h55, 8'h5D, 8'h5F: begin
        // push return address, predecrement
        wr_addr = sp - {29'h0, kw[1:0], 1'b0};
        wr_len = {kw[1:0], 1'b0};
        wr_data = adv_reg ? {pc_ret, 16'h0000} : {pc_ret[15:0], 32'h0000_0000};
        er_we = 1'b1;
        er_dat = wr_addr;
        if (insn_reg[31:24] == 8'h55) begin
          pc_next = pc_ret + {{24{insn_reg[23]}}, insn_reg[23:16]};
          cost_next = cost(8'h02, 8'h00, kw, 8'h00, 8'h00, 8'h01, sacc(sp), 8'h01);
        end else if (insn_reg[31:24] == 8'h5D) begin
          pc_next = er[insn_reg[22:20]];
          cost_next = cost(8'h02, 8'h00, kw, 8'h00, 8'h00, 8'h01, sacc(sp), 8'h01);
        end else begin
          vaddr = {24'h0, insn_reg[23:16]};
          pc_next = adv_reg ? {8'h00, mem[vaddr[AW-1:0] + 1], mem[vaddr[AW-1:0] + 2], mem[vaddr[AW-1:0] + 3]}
                            : {16'h0000, mem[vaddr[AW-1:0]], mem[vaddr[AW-1:0] + 1]};
          cost_next = cost(8'h02, kw, kw, 8'h00, 8'h00, sacc(vaddr), sacc(sp), 8'h01);
        end
      end
      8'h54, 8'h56: begin
        if (insn_reg[31:24] == 8'h56) begin
          ccr_next = mem[sp[AW-1:0]]; // all flags restored
          vaddr = sp + 32'h2;
        end else begin
          vaddr = sp; // flags untouched
        end
        pc_next = adv_reg ? {8'h00, mem[vaddr[AW-1:0] + 1], mem[vaddr[AW-1:0] + 2], mem[vaddr[AW-1:0] + 3]}
                          : {16'h0000, mem[vaddr[AW-1:0]], mem[vaddr[AW-1:0] + 1]};
        er_we = 1'b1;
        er_dat = vaddr + {29'h0, kw[1:0], 1'b0}; // postincrement past the frame
        cost_next = cost(8'h02, 8'h00, (insn_reg[31:24] == 8'h56) ? 8'h02 : kw, 8'h00, 8'h00,
                         8'h01, sacc(sp), 8'h01) + 8'h02;
      end
      8'h57: begin
        // pc first, then ccr below it
        wr_addr = sp - (adv_reg ? 32'h6 : 32'h4);
        wr_len = adv_reg ? 3'd6 : 3'd4;
        wr_data = adv_reg ? {ccr_reg, ccr_reg, pc_reg + 32'h2} : {ccr_reg, ccr_reg, pc_ret[15:0], 16'h0000};
        er_we = 1'b1;
        er_dat = wr_addr;
        ccr_next[`CFS_CCR_I] = 1'b1;
        vaddr = TRAP_VEC_BASE + (adv_reg ? {28'h0, insn_reg[21:20], 2'b00} : {29'h0, insn_reg[21:20], 1'b0});
        pc_next = adv_reg ? {8'h00, mem[vaddr[AW-1:0] + 1], mem[vaddr[AW-1:0] + 2], mem[vaddr[AW-1:0] + 3]}
                          : {16'h0000, mem[vaddr[AW-1:0]], mem[vaddr[AW-1:0] + 1]};
        cost_next = cost(8'h02, kw, 8'h02, 8'h00, 8'h00, sacc(vaddr), sacc(sp), 8'h01) + 8'h04;
      end
      8'h7B: begin
        if (insn_reg[15:0] == 16'h598F) begin
          copy_go = 1'b1; // byte or word count by nibble msb
          pc_next = pc_reg + 32'h4;
          cost_next = `CFS_COPY_BASE;
        end else begin
          err_next = 1'b1;
        end
      end
      default: err_next = 1'b1;
    endcase
    if (err_next) begin
      er_we = 1'b0;
      wr_len = 3'd0;
      sleep_set = 1'b0;
      copy_go = 1'b0;
      ccr_next = ccr_reg;
    end
  end

  // copy count for the current form, zero means nothing to do
  wire [15:0] copy_cnt = word_copy_reg ? er[4][15:0] : {8'h00, er[4][7:0]};
  wire [15:0] copy_left = copy_cnt - 16'h0001;

  // ----------------------------------------
  // flag unit
  // ----------------------------------------
  reg [7:0] fccr;
  reg [8:0] fsum;
  always @* begin
    fccr = ccr_reg;
    fsum = 9'h000;
    case (w_data[2:0])
      `CFS_FOP_ADDW: fccr[`CFS_CCR_H] = |(({1'b0, flag_a_reg[11:0]} + {1'b0, flag_b_reg[11:0]}) >> 12);
      `CFS_FOP_SUBW: fccr[`CFS_CCR_H] = flag_a_reg[11:0] < flag_b_reg[11:0];
      `CFS_FOP_ADDL: fccr[`CFS_CCR_H] = |(({1'b0, flag_a_reg[27:0]} + {1'b0, flag_b_reg[27:0]}) >> 28);
      `CFS_FOP_SUBL: fccr[`CFS_CCR_H] = flag_a_reg[27:0] < flag_b_reg[27:0];
      `CFS_FOP_ADDX: begin
        fsum = {1'b0, flag_a_reg[7:0]} + {1'b0, flag_b_reg[7:0]} + {8'h00, ccr_reg[`CFS_CCR_C]};
        if (fsum[7:0] != 8'h00) fccr[`CFS_CCR_Z] = 1'b0; // zero keeps old Z
      end
      `CFS_FOP_DADJ: begin
        fsum = {1'b0, flag_a_reg[7:0]}
             + ((ccr_reg[`CFS_CCR_H] || flag_a_reg[3:0] > 4'h9) ? 9'h006 : 9'h000)
             + ((ccr_reg[`CFS_CCR_C] || flag_a_reg[7:0] > 8'h99) ? 9'h060 : 9'h000);
        if (fsum[8] || flag_a_reg[7:0] > 8'h99) fccr[`CFS_CCR_C] = 1'b1; // else kept
      end
      `CFS_FOP_DIVS: begin
        fccr[`CFS_CCR_N] = flag_b_reg[7];
        fccr[`CFS_CCR_Z] = flag_b_reg[7:0] == 8'h00;
      end
      default: begin
        fccr[`CFS_CCR_N] = (flag_a_reg[15] ^ flag_b_reg[7]) && flag_b_reg[7:0] != 8'h00;
        fccr[`CFS_CCR_Z] = flag_b_reg[7:0] == 8'h00;
      end
    endcase
  end

  // ----------------------------------------
  // axi handshake next values
  // ----------------------------------------
  wire aw_take = s_axi_awvalid & s_axi_awready;
  wire w_take = s_axi_wvalid & s_axi_wready;
  wire wr_fire = aw_full & w_full & ~s_axi_bvalid; // both halves present, response slot free
  wire ar_take = s_axi_arvalid & s_axi_arready;
  wire idle = (state_reg == ST_IDLE);
  wire aw_full_n = (aw_full | aw_take) & ~wr_fire;
  wire w_full_n = (w_full | w_take) & ~wr_fire;
  wire bvalid_n = (s_axi_bvalid & ~s_axi_bready) | wr_fire;
  wire rvalid_n = (s_axi_rvalid & ~s_axi_rready) | ar_take;
  wire [31:0] wv = w_data;

  // read mux, unmapped offsets answer zero with a slave error
  reg [31:0] rd_val;
  reg rd_err;
  always @* begin
    rd_err = 1'b0;
    case (s_axi_araddr)
      `CFS_OFF_CTRL: rd_val = {30'h0, adv_reg, 1'b0};
      `CFS_OFF_STATUS: rd_val = {29'h0, err_reg, sleep, ~idle}; // block's own state
      `CFS_OFF_INSN: rd_val = insn_reg;
      `CFS_OFF_EXT: rd_val = ext_reg;
      `CFS_OFF_PC: rd_val = pc_reg;
      `CFS_OFF_CCR: rd_val = {24'h0, ccr_reg};
      `CFS_OFF_STATES: rd_val = {24'h0, states_reg};
      `CFS_OFF_REG_SEL: rd_val = {29'h0, reg_sel_reg};
      `CFS_OFF_REG_DATA: rd_val = er[reg_sel_reg];
      `CFS_OFF_MEM_ADDR: rd_val = {{(32-AW){1'b0}}, mem_addr_reg};
      `CFS_OFF_MEM_DATA: rd_val = {24'h0, mem[mem_addr_reg]};
      `CFS_OFF_FLAG_A: rd_val = flag_a_reg;
      `CFS_OFF_FLAG_B: rd_val = flag_b_reg;
      default: begin
        rd_val = 32'h0000_0000;
        rd_err = 1'b1;
      end
    endcase
  end

  // ----------------------------------------
  // sequencer, architectural state and bus slave
  // ----------------------------------------
  integer q;
  always @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      state_reg <= ST_IDLE;
      pc_reg <= `CFS_PC_RESET;
      ccr_reg <= `CFS_CCR_RESET;
      insn_reg <= 32'h0000_0000;
      ext_reg <= 32'h0000_0000;
      adv_reg <= 1'b0;
      err_reg <= 1'b0;
      states_reg <= 8'h00;
      wait_reg <= 8'h00;
      sub_reg <= 2'h0;
      word_copy_reg <= 1'b0;
      reg_sel_reg <= 3'h0;
      mem_addr_reg <= {AW{1'b0}};
      flag_a_reg <= 32'h0000_0000;
      flag_b_reg <= 32'h0000_0000;
      for (q = 0; q < 8; q = q + 1) er[q] <= 32'h0000_0000;
      aw_full <= 1'b0;
      w_full <= 1'b0;
      aw_addr <= 8'h00;
      w_data <= 32'h0000_0000;
      w_strb <= 4'h0;
      s_axi_awready <= 1'b0;
      s_axi_wready <= 1'b0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= 2'b00;
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0000_0000;
      s_axi_rresp <= 2'b00;
      busy <= 1'b0;
      sleep <= 1'b0;
    end else begin
      // address and data are caught in either order
      if (aw_take) aw_addr <= s_axi_awaddr;
      if (w_take) begin
        w_data <= s_axi_wdata;
        w_strb <= s_axi_wstrb;
      end
      aw_full <= aw_full_n;
      w_full <= w_full_n;
      s_axi_awready <= ~aw_full_n & ~bvalid_n;
      s_axi_wready <= ~w_full_n & ~bvalid_n;
      s_axi_bvalid <= bvalid_n;
      s_axi_rvalid <= rvalid_n;
      s_axi_arready <= ~rvalid_n;
      if (ar_take) begin
        s_axi_rdata <= rd_val;
        s_axi_rresp <= rd_err ? 2'b10 : 2'b00;
      end
      if (wr_fire) begin
        s_axi_bresp <= (aw_addr > `CFS_OFF_FLAG_OP || aw_addr[1:0] != 2'b00 ||
                        aw_addr == `CFS_OFF_STATUS || aw_addr == `CFS_OFF_STATES) ? 2'b10 : 2'b00;
        // state-changing writes only land while no instruction runs, except the ctrl mode bit adv_reg
        if (aw_addr == `CFS_OFF_CTRL) begin
          if (w_strb[0]) adv_reg <= wv[`CFS_CTRL_ADV];
          if (w_strb[0] && wv[`CFS_CTRL_START] && idle) begin
            state_reg <= ST_EXEC;
            sleep <= 1'b0; // a new start wakes the core
          end
        end
        if (idle) begin
          case (aw_addr)
            `CFS_OFF_INSN: insn_reg <= merge(insn_reg, wv, w_strb);
            `CFS_OFF_EXT: ext_reg <= merge(ext_reg, wv, w_strb);
            `CFS_OFF_PC: pc_reg <= merge(pc_reg, wv, w_strb);
            `CFS_OFF_CCR: if (w_strb[0]) ccr_reg <= wv[7:0];
            `CFS_OFF_REG_SEL: if (w_strb[0]) reg_sel_reg <= wv[2:0];
            `CFS_OFF_REG_DATA: er[reg_sel_reg] <= merge(er[reg_sel_reg], wv, w_strb);
            `CFS_OFF_MEM_ADDR: if (w_strb[0]) mem_addr_reg <= wv[AW-1:0];
            `CFS_OFF_MEM_DATA: if (w_strb[0]) mem[mem_addr_reg] <= wv[7:0];
            `CFS_OFF_FLAG_A: flag_a_reg <= merge(flag_a_reg, wv, w_strb);
            `CFS_OFF_FLAG_B: flag_b_reg <= merge(flag_b_reg, wv, w_strb);
            `CFS_OFF_FLAG_OP: if (w_strb[0]) ccr_reg <= fccr;
            default: ;
          endcase
        end
      end
      // instruction sequencer
      case (state_reg)
        ST_IDLE: busy <= 1'b0;
        ST_EXEC: begin
          busy <= 1'b1;
          err_reg <= err_next;
          pc_reg <= err_next ? pc_reg : pc_next;
          ccr_reg <= ccr_next;
          if (er_we) er[er_idx] <= er_dat;
          for (q = 0; q < 6; q = q + 1) begin
            if (q < wr_len) mem[wr_addr[AW-1:0] + q[AW-1:0]] <= wr_data[47 - q*8 -: 8];
          end
          if (sleep_set) sleep <= 1'b1;
          states_reg <= err_next ? 8'h02 : cost_next;
          // the exec state is one state; a copy also spends its own states in the copy loop
          wait_reg <= (err_next ? 8'h02 : cost_next) - (copy_go ? 8'h02 : 8'h01);
          word_copy_reg <= second_of_cell(insn_reg[23:16]);
          sub_reg <= 2'h0;
          // first state spent here, the rest counted down in wait
          state_reg <= copy_go ? ST_COPY : ST_WAIT;
        end
        ST_COPY: begin
          if (copy_cnt == 16'h0000) begin
            state_reg <= ST_WAIT; // zero count moves nothing
            wait_reg <= wait_reg - 8'h01; // this check state is part of the base count
          end else begin
            sub_reg <= sub_reg + 2'h1;
            if (sub_reg == `CFS_COPY_PER_BYTE) begin
              // four states per byte moved
              mem[er[6][AW-1:0]] <= mem[er[5][AW-1:0]];
              er[5] <= er[5] + 32'h1;
              er[6] <= er[6] + 32'h1;
              if (word_copy_reg) er[4][15:0] <= copy_left;
              else er[4][7:0] <= copy_left[7:0];
              states_reg <= states_reg + 8'h04;
              if (copy_left == 16'h0000) state_reg <= ST_WAIT;
            end
          end
        end
        ST_WAIT: begin
          if (wait_reg == 8'h00) begin
            state_reg <= ST_IDLE;
            busy <= 1'b0;
          end else begin
            wait_reg <= wait_reg - 8'h01;
          end
        end
        default: state_reg <= ST_IDLE;
      endcase
    end
  end

endmodule

// ### cfs_defs.vh
// Purpose: constants for the control-flow and system-op execution unit
// Assumes: 32-bit AXI4-Lite register window, byte offsets below
// Notes: condition register layout is I UI H U N Z V C, bit 7 down to 0
`ifndef CFS_DEFS_VH
`define CFS_DEFS_VH

// ----------------------------------------
// register offsets (byte addresses)
// ----------------------------------------
`define CFS_OFF_CTRL 8'h00
`define CFS_OFF_STATUS 8'h04
`define CFS_OFF_INSN 8'h08
`define CFS_OFF_EXT 8'h0C
`define CFS_OFF_PC 8'h10
`define CFS_OFF_CCR 8'h14
`define CFS_OFF_STATES 8'h18
`define CFS_OFF_REG_SEL 8'h1C
`define CFS_OFF_REG_DATA 8'h20
`define CFS_OFF_MEM_ADDR 8'h24
`define CFS_OFF_MEM_DATA 8'h28
`define CFS_OFF_FLAG_A 8'h2C
`define CFS_OFF_FLAG_B 8'h30
`define CFS_OFF_FLAG_OP 8'h34

// ----------------------------------------
// field positions and reset values
// ----------------------------------------
`define CFS_CTRL_START 0
`define CFS_CTRL_ADV 1
`define CFS_STAT_BUSY 0
`define CFS_STAT_SLEEP 1
`define CFS_STAT_ERR 2
`define CFS_CCR_I 7
`define CFS_CCR_H 5
`define CFS_CCR_N 3
`define CFS_CCR_Z 2
`define CFS_CCR_C 0
`define CFS_CCR_RESET 8'h80
`define CFS_PC_RESET 32'h0000_0000

// ----------------------------------------
// timing counts, in states (one state per ref_clk cycle)
// ----------------------------------------
`define CFS_S_MEM 8'h02
`define CFS_S_INTERNAL 8'h01
`define CFS_COPY_BASE 8'h08
`define CFS_COPY_PER_BYTE 2'h3

// ----------------------------------------
// flag-unit operation codes
// ----------------------------------------
`define CFS_FOP_ADDW 3'h0
`define CFS_FOP_SUBW 3'h1
`define CFS_FOP_ADDL 3'h2
`define CFS_FOP_SUBL 3'h3
`define CFS_FOP_ADDX 3'h4
`define CFS_FOP_DADJ 3'h5
`define CFS_FOP_DIVS 3'h6
`define CFS_FOP_DIVQ 3'h7

`endif

// ### cfs_exec_asserts.sv
// Purpose: port checker for the execution unit
// Assumes: one clock, asynchronous active-high reset
// Notes: watches the register bus handshake and the busy window
`timescale 1ns/1ps
// ----------------------------------------
// checker
// ----------------------------------------
module cfs_exec_asserts (
  // clock and reset
  input wire logic ref_clk,
  input wire logic reset,
  // watched bus signals
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic s_axi_awready,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [1:0] s_axi_bresp,
  // core status
  input wire logic busy
);
  default clocking @(posedge ref_clk); endclocking
  default disable iff (reset);
  // shortest instruction is two states
  sequence s_start;
    $rose(busy);
  endsequence
  a_busy_min_two: assert property (s_start |-> busy[*2]) else $error("busy too short");
  a_busy_bounded: assert property (s_start |-> ##[1:40] !busy) else $error("busy never ends");
  a_rvalid_holds: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read data dropped");
  a_bvalid_holds: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
    else $error("write response dropped");
  a_read_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid) else $error("read late");
  a_ar_blocked: assert property (s_axi_rvalid |-> !s_axi_arready) else $error("ar open with data");
  a_aw_blocked: assert property (s_axi_bvalid |-> !s_axi_awready) else $error("aw open with resp");
  a_resp_release: assert property (s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid) else $error("resp stuck");
endmodule

bind cfs_exec cfs_exec_asserts cfs_exec_asserts_inst (.ref_clk(ref_clk), .reset(reset),
  .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready), .s_axi_rvalid(s_axi_rvalid),
  .s_axi_rready(s_axi_rready), .s_axi_rdata(s_axi_rdata), .s_axi_awready(s_axi_awready),
  .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready), .s_axi_bresp(s_axi_bresp), .busy(busy));

// ### cfs_stack_model.sv
// Purpose: reference for stack pointer movement on calls
// Assumes: normal mode pushes a 16-bit word
// Notes: the memory itself sits inside the block; only the pointer is modelled
`timescale 1ns/1ps
module cfs_stack_model;
  // a push predecrements before the store
  function automatic logic [31:0] push_w(input logic [31:0] sp);
    return sp - 32'h0000_0002;
  endfunction
endmodule

// ### tb.sv
// Purpose: self-checking bench for the execution unit
// Assumes: registers reached over the register bus only
// Notes: expectations come from the instruction rules
`timescale 1ns/1ps
`include "cfs_defs.vh"
`define CHK(g, e) begin check_count++; if ((g) !== (e)) begin mismatches++; \
  $display("wrong value t=%0t got %h exp %h", $time, g, e); end end
module tb;
  logic ref_clk = 0, reset = 1, awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
  logic [7:0] awaddr = 8'h00, araddr = 8'h00;
  logic [31:0] wdata = 32'h0000_0000, rdata, q;
  logic [1:0] bresp, rresp;
  logic awready, wready, bvalid, arready, rvalid, busy, sleep;
  int mismatches = 0, check_count = 0;
  cfs_exec cfs_exec_inst (.ref_clk(ref_clk), .reset(reset), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
    .s_axi_awaddr(awaddr), .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_wdata(wdata),
    .s_axi_wstrb(4'hF), .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_bresp(bresp),
    .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_araddr(araddr), .s_axi_rvalid(rvalid),
    .s_axi_rready(rready), .s_axi_rdata(rdata), .s_axi_rresp(rresp), .busy(busy), .sleep(sleep));
  cfs_stack_model cfs_stack_model_inst ();
  initial forever #2.5 ref_clk = ~ref_clk;
  task automatic conclude();
    $display("comparisons %0d mismatches %0d", check_count, mismatches);
    if (mismatches == 0 && check_count > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  // both channels offered together, each released when taken
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge ref_clk);
    awaddr <= a; wdata <= d; awvalid <= 1; wvalid <= 1; bready <= 1;
    while (awvalid || wvalid || !bvalid) begin
      @(posedge ref_clk);
      if (awvalid && awready) awvalid <= 0;
      if (wvalid && wready) wvalid <= 0;
    end
    bready <= 0;
  endtask
  task automatic rd(input logic [7:0] a);
    @(posedge ref_clk);
    araddr <= a; arvalid <= 1; rready <= 1;
    do begin
      @(posedge ref_clk);
      if (arready) arvalid <= 0;
    end while (!rvalid);
    q = rdata; rready <= 0;
  endtask
  task automatic exec(input logic [31:0] insn, input logic [7:0] states);
    int n;
    wr(`CFS_OFF_INSN, insn); wr(`CFS_OFF_CTRL, 32'h0000_0001);
    @(posedge ref_clk);
    for (n = 0; n < 50 && busy !== 1'b0; n++) @(posedge ref_clk);
    `CHK(busy, 1'b0)
    rd(`CFS_OFF_STATES); `CHK(q, {24'h0, states})
  endtask
  task automatic t_reset();
    rd(`CFS_OFF_CCR); `CHK(q, 32'h0000_0080)
    rd(8'h3C); `CHK(rresp, 2'b10)
  endtask
  // or, xor, and immediates in turn against a running value
  task automatic t_ccr_imm();
    logic [7:0] c;
    c = 8'h80;
    exec(32'h0405_0000, 8'h02); c = c | 8'h05; rd(`CFS_OFF_CCR); `CHK(q[7:0], c)
    exec(32'h0581_0000, 8'h02); c = c ^ 8'h81; rd(`CFS_OFF_CCR); `CHK(q[7:0], c)
    exec(32'h0606_0000, 8'h02); c = c & 8'h06; rd(`CFS_OFF_CCR); `CHK(q[7:0], c)
  endtask
  task automatic t_sleep();
    exec(32'h0180_0000, 8'h02);
    rd(`CFS_OFF_STATUS); `CHK(q[1], 1'b1)
    `CHK(sleep, 1'b1)
    rd(`CFS_OFF_CCR); `CHK(q[7:0], 8'h04)
  endtask
  task automatic t_call_reg();
    wr(`CFS_OFF_REG_SEL, 32'h7); wr(`CFS_OFF_REG_DATA, 32'h80);
    wr(`CFS_OFF_REG_SEL, 32'h1); wr(`CFS_OFF_REG_DATA, 32'h40);
    exec(32'h5D10_0000, 8'h06); rd(`CFS_OFF_PC); `CHK(q, 32'h0000_0040)
    wr(`CFS_OFF_REG_SEL, 32'h7); rd(`CFS_OFF_REG_DATA);
    `CHK(q, cfs_stack_model_inst.push_w(32'h80))
  endtask
  // trap frame then exception return restores ccr and pc
  task automatic t_trap_rte();
    wr(`CFS_OFF_MEM_ADDR, 32'h0000_0010); wr(`CFS_OFF_MEM_DATA, 32'h0000_0000);
    wr(`CFS_OFF_MEM_ADDR, 32'h0000_0011); wr(`CFS_OFF_MEM_DATA, 32'h0000_0060);
    wr(`CFS_OFF_CCR, 32'h0000_0005);
    exec(32'h5700_0000, 8'h0E); rd(`CFS_OFF_PC); `CHK(q, 32'h0000_0060)
    rd(`CFS_OFF_CCR); `CHK(q[7:0], 8'h85)
    rd(`CFS_OFF_REG_DATA); `CHK(q, 32'h0000_007A)
    wr(`CFS_OFF_CCR, 32'h0000_0000);
    exec(32'h5670_0000, 8'h0A); rd(`CFS_OFF_CCR); `CHK(q[7:0], 8'h05)
    rd(`CFS_OFF_PC); `CHK(q, 32'h0000_0042)
    rd(`CFS_OFF_REG_DATA); `CHK(q, 32'h0000_007E)
  endtask
  task automatic t_flags();
    wr(`CFS_OFF_FLAG_A, 32'h0FFF); wr(`CFS_OFF_FLAG_B, 32'h1); wr(`CFS_OFF_FLAG_OP, 32'h0);
    rd(`CFS_OFF_CCR); `CHK(q[`CFS_CCR_H], 1'b1)
    wr(`CFS_OFF_FLAG_B, 32'h0); wr(`CFS_OFF_FLAG_OP, 32'h6);
    rd(`CFS_OFF_CCR); `CHK(q[`CFS_CCR_Z], 1'b1)
  endtask
  initial begin
    repeat (16) @(posedge ref_clk);
    reset <= 0;
    repeat (2) @(posedge ref_clk);
    t_reset(); t_ccr_imm(); t_sleep(); t_call_reg(); t_flags(); t_trap_rte();
    conclude();
  end
  initial begin
    #100000;
    mismatches++;
    conclude();
  end
endmodule
